// File: hw/dbc_pkg.sv
// Purpose: shared constants of the debug bus comparators
// Assumes: byte-wide register port, byte addresses as offsets
// Notes:   control registers hold only their defined bits
package dbc_pkg;

  localparam int addr_width = 16;
  localparam int bus_addr_width = 24;
  localparam int bus_data_width = 32;
  localparam int ctl_width = 8;

  // register byte addresses
  localparam logic [15:0] off_a_mask0      = 16'h011c;
  localparam logic [15:0] off_a_mask1      = 16'h011d;
  localparam logic [15:0] off_a_mask2      = 16'h011e;
  localparam logic [15:0] off_a_mask3      = 16'h011f;
  localparam logic [15:0] off_b_ctl        = 16'h0120;
  localparam logic [15:0] off_b_addr_high  = 16'h0125;
  localparam logic [15:0] off_b_addr_mid   = 16'h0126;
  localparam logic [15:0] off_b_addr_low   = 16'h0127;
  localparam logic [15:0] off_c_ctl        = 16'h0130;
  localparam logic [15:0] off_status       = 16'h0150;
  localparam logic [15:0] off_irq_mask     = 16'h0151;

  // control register fields
  localparam int ctl_enable_bit = 0;
  localparam int ctl_rwe_bit    = 2;
  localparam int ctl_rw_bit     = 3;
  localparam int ctl_instruction_select_bit   = 5;
  localparam int ctl_ndb_bit    = 6;

  // bits that exist in each control register
  localparam logic [7:0] b_ctl_bits = 8'h2d;
  localparam logic [7:0] c_ctl_bits = 8'h6d;

  // reset values
  localparam logic [7:0]  ctl_reset    = 8'h00;
  localparam logic [23:0] addr_reset   = 24'h000000;
  localparam logic [31:0] mask_reset   = 32'h00000000;
  localparam logic [3:0]  status_reset = 4'h0;
  localparam logic [7:0]  rdata_reset  = 8'h00;

  // event bits of status and irq mask
  localparam int ev_match_a = 0;
  localparam int ev_match_b = 1;
  localparam int ev_match_c = 2;
  localparam int ev_refused = 3;
  localparam int ev_count   = 4;

endpackage

// File: hw/dbc_comparator.sv
// Purpose: one address/data/read-write comparator
// Assumes: bus and pc inputs are on sys_clk
// Notes:   hit is combinational, registered by the caller
module dbc_comparator #(
  parameter bit has_data = 1'b1
) (
  input  wire logic        enable,
  input  wire logic        instruction_select_sel,
  input  wire logic        rw_qualify,
  input  wire logic        rw_value,
  input  wire logic        inequality,
  input  wire logic [23:0] addr_value,
  input  wire logic [31:0] data_value,
  input  wire logic [31:0] data_mask,
  input  wire logic [23:0] bus_address,
  input  wire logic [31:0] bus_data,
  input  wire logic        bus_rw,
  input  wire logic        bus_valid,
  input  wire logic [23:0] pc_address,
  input  wire logic        pc_valid,
  output logic             hit
);

  logic [23:0] sel_address;
  logic        cycle_ok;
  logic        addr_ok;
  logic        data_equal;
  logic        data_ok;
  logic        rw_ok;

  always_comb begin
    // pc or data access address
    sel_address = instruction_select_sel ? pc_address : bus_address;
    cycle_ok    = instruction_select_sel ? pc_valid : bus_valid;
    addr_ok     = (sel_address == addr_value);
    // only mask-one bits take part
    data_equal  = ((bus_data ^ data_value) & data_mask) == 32'h00000000;
    if (!has_data || instruction_select_sel) begin
      data_ok = 1'b1;
    end else begin
      data_ok = inequality ? !data_equal : data_equal;
    end
    // qualifier ignored under instruction select
    rw_ok = instruction_select_sel || !rw_qualify || (bus_rw == rw_value);
    hit   = enable && cycle_ok && addr_ok && data_ok && rw_ok;
  end

endmodule

// File: hw/dbc_event_flags.sv
// Purpose: sticky event flags, mask and interrupt line
// Assumes: clear_all is a one-cycle read pulse of the status register
// Notes:   a set in the clearing cycle survives
module dbc_event_flags #(
  parameter int n = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [n-1:0] event_set,
  input  wire logic         clear_all,
  input  wire logic [n-1:0] irq_mask,
  output logic      [n-1:0] status,
  output logic              irq
);

  genvar i;
  generate
    for (i = 0; i < n; i++) begin : g_flag
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          status[i] <= 1'b0;
        end else if (event_set[i]) begin
          status[i] <= 1'b1;
        end else if (clear_all) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status & irq_mask);

endmodule

// File: hw/dbc_debug_comparators.sv
// Purpose: comparator registers and match logic of the debug module
// Assumes: monitored bus, pc and control inputs come from sys_clk logic
// Notes:   matches appear one cycle after the bus cycle that caused them
// Contract
// - reads always; comparator writes only unarmed, trace inactive
// - mask byte 0 is bits 31..24
// - mask zero excludes data bit, one includes
// - instruction select picks pc over data address
// - rw value: 0 write, 1 read
// - rw qualify enable adds bus rw to compare
// - enable bit off means no match
// - range mode: b uses a control only
// - qualified: bus rw must equal rw value
// - b address 24 bits matched exactly
// - inequality bit inverts c data match
// - data bit compared only where mask one
module dbc_debug_comparators (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] reg_address,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        armed,
  input  wire logic        trace_active,
  input  wire logic        ab_pairing_mode,
  input  wire logic [7:0]  cmp_a_control,
  input  wire logic [23:0] cmp_a_address,
  input  wire logic [31:0] cmp_a_data,
  input  wire logic [23:0] cmp_c_address,
  input  wire logic [31:0] cmp_c_data,
  input  wire logic [31:0] cmp_c_data_mask,
  input  wire logic [23:0] bus_address,
  input  wire logic [31:0] bus_data,
  input  wire logic        bus_rw,
  input  wire logic        bus_valid,
  input  wire logic [23:0] pc_address,
  input  wire logic        pc_valid,
  output logic             match_a,
  output logic             match_b,
  output logic             match_c,
  output logic             irq
);

  logic [31:0] cmp_a_data_mask;
  logic [7:0]  cmp_b_control;
  logic [23:0] cmp_b_address;
  logic [7:0]  cmp_c_control;
  logic [3:0]  irq_mask;
  logic [3:0]  status;
  logic [7:0]  b_ctl_eff;
  logic        write_open;
  logic        cmp_reg_hit;
  logic        cmp_write;
  logic        refused;
  logic        hit_a;
  logic        hit_b;
  logic        hit_c;
  logic        status_read;

  assign write_open = !armed && !trace_active;

  always_comb begin
    case (reg_address)
      dbc_pkg::off_a_mask0,
      dbc_pkg::off_a_mask1,
      dbc_pkg::off_a_mask2,
      dbc_pkg::off_a_mask3,
      dbc_pkg::off_b_ctl,
      dbc_pkg::off_b_addr_high,
      dbc_pkg::off_b_addr_mid,
      dbc_pkg::off_b_addr_low,
      dbc_pkg::off_c_ctl: cmp_reg_hit = 1'b1;
      default:            cmp_reg_hit = 1'b0;
    endcase
  end

  assign cmp_write   = reg_write && cmp_reg_hit && write_open;
  assign refused     = reg_write && cmp_reg_hit && !write_open;
  assign status_read = reg_read && (reg_address == dbc_pkg::off_status);

  // data mask, byte 0 on top
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmp_a_data_mask <= dbc_pkg::mask_reset;
    end else if (cmp_write) begin
      case (reg_address)
        dbc_pkg::off_a_mask0: cmp_a_data_mask[31:24] <= reg_wdata;
        dbc_pkg::off_a_mask1: cmp_a_data_mask[23:16] <= reg_wdata;
        dbc_pkg::off_a_mask2: cmp_a_data_mask[15:8] <= reg_wdata;
        dbc_pkg::off_a_mask3: cmp_a_data_mask[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmp_b_control <= dbc_pkg::ctl_reset;
    end else if (cmp_write && reg_address == dbc_pkg::off_b_ctl) begin
      cmp_b_control <= reg_wdata & dbc_pkg::b_ctl_bits;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmp_b_address <= dbc_pkg::addr_reset;
    end else if (cmp_write) begin
      case (reg_address)
        dbc_pkg::off_b_addr_high: cmp_b_address[23:16] <= reg_wdata;
        dbc_pkg::off_b_addr_mid:  cmp_b_address[15:8] <= reg_wdata;
        dbc_pkg::off_b_addr_low:  cmp_b_address[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmp_c_control <= dbc_pkg::ctl_reset;
    end else if (cmp_write && reg_address == dbc_pkg::off_c_ctl) begin
      cmp_c_control <= reg_wdata & dbc_pkg::c_ctl_bits;
    end
  end

  // interrupt mask is not locked by arming
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_mask <= dbc_pkg::status_reset;
    end else if (reg_write && reg_address == dbc_pkg::off_irq_mask) begin
      irq_mask <= reg_wdata[3:0];
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= dbc_pkg::rdata_reset;
    end else if (reg_read) begin
      case (reg_address)
        dbc_pkg::off_a_mask0:     reg_rdata <= cmp_a_data_mask[31:24];
        dbc_pkg::off_a_mask1:     reg_rdata <= cmp_a_data_mask[23:16];
        dbc_pkg::off_a_mask2:     reg_rdata <= cmp_a_data_mask[15:8];
        dbc_pkg::off_a_mask3:     reg_rdata <= cmp_a_data_mask[7:0];
        dbc_pkg::off_b_ctl:       reg_rdata <= cmp_b_control;
        dbc_pkg::off_b_addr_high: reg_rdata <= cmp_b_address[23:16];
        dbc_pkg::off_b_addr_mid:  reg_rdata <= cmp_b_address[15:8];
        dbc_pkg::off_b_addr_low:  reg_rdata <= cmp_b_address[7:0];
        dbc_pkg::off_c_ctl:       reg_rdata <= cmp_c_control;
        dbc_pkg::off_status:      reg_rdata <= {4'h0, status};
        dbc_pkg::off_irq_mask:    reg_rdata <= {4'h0, irq_mask};
        default:                  reg_rdata <= dbc_pkg::rdata_reset;
      endcase
    end else begin
      reg_rdata <= dbc_pkg::rdata_reset;
    end
  end

  // range mode: comparator b follows a's control
  assign b_ctl_eff = ab_pairing_mode ? cmp_a_control : cmp_b_control;

  dbc_comparator #(.has_data(1'b1)) u_cmp_a (
    .enable      (cmp_a_control[dbc_pkg::ctl_enable_bit]),
    .instruction_select_sel    (cmp_a_control[dbc_pkg::ctl_instruction_select_bit]),
    .rw_qualify  (cmp_a_control[dbc_pkg::ctl_rwe_bit]),
    .rw_value    (cmp_a_control[dbc_pkg::ctl_rw_bit]),
    .inequality  (1'b0),
    .addr_value  (cmp_a_address),
    .data_value  (cmp_a_data),
    .data_mask   (cmp_a_data_mask),
    .bus_address (bus_address),
    .bus_data    (bus_data),
    .bus_rw      (bus_rw),
    .bus_valid   (bus_valid),
    .pc_address  (pc_address),
    .pc_valid    (pc_valid),
    .hit         (hit_a)
  );

  dbc_comparator #(.has_data(1'b0)) u_cmp_b (
    .enable      (b_ctl_eff[dbc_pkg::ctl_enable_bit]),
    .instruction_select_sel    (b_ctl_eff[dbc_pkg::ctl_instruction_select_bit]),
    .rw_qualify  (b_ctl_eff[dbc_pkg::ctl_rwe_bit]),
    .rw_value    (b_ctl_eff[dbc_pkg::ctl_rw_bit]),
    .inequality  (1'b0),
    .addr_value  (cmp_b_address),
    .data_value  (32'h00000000),
    .data_mask   (32'h00000000),
    .bus_address (bus_address),
    .bus_data    (bus_data),
    .bus_rw      (bus_rw),
    .bus_valid   (bus_valid),
    .pc_address  (pc_address),
    .pc_valid    (pc_valid),
    .hit         (hit_b)
  );

  dbc_comparator #(.has_data(1'b1)) u_cmp_c (
    .enable      (cmp_c_control[dbc_pkg::ctl_enable_bit]),
    .instruction_select_sel    (cmp_c_control[dbc_pkg::ctl_instruction_select_bit]),
    .rw_qualify  (cmp_c_control[dbc_pkg::ctl_rwe_bit]),
    .rw_value    (cmp_c_control[dbc_pkg::ctl_rw_bit]),
    .inequality  (cmp_c_control[dbc_pkg::ctl_ndb_bit]),
    .addr_value  (cmp_c_address),
    .data_value  (cmp_c_data),
    .data_mask   (cmp_c_data_mask),
    .bus_address (bus_address),
    .bus_data    (bus_data),
    .bus_rw      (bus_rw),
    .bus_valid   (bus_valid),
    .pc_address  (pc_address),
    .pc_valid    (pc_valid),
    .hit         (hit_c)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      match_a <= 1'b0;
      match_b <= 1'b0;
      match_c <= 1'b0;
    end else begin
      match_a <= hit_a;
      match_b <= hit_b;
      match_c <= hit_c;
    end
  end

  dbc_event_flags #(.n(dbc_pkg::ev_count)) u_flags (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .event_set ({refused, match_c, match_b, match_a}),
    .clear_all (status_read),
    .irq_mask  (irq_mask),
    .status    (status),
    .irq       (irq)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_write_locked: assert property (
    reg_write && reg_address == dbc_pkg::off_b_ctl && !write_open
    |=> $stable(cmp_b_control) && status[dbc_pkg::ev_refused])
    else $error("locked control write changed register");

  a_write_taken: assert property (
    reg_write && reg_address == dbc_pkg::off_c_ctl && write_open
    |=> cmp_c_control == ($past(reg_wdata) & dbc_pkg::c_ctl_bits))
    else $error("open control write not stored");

  a_read_back: assert property (
    reg_read && reg_address == dbc_pkg::off_c_ctl
    |=> reg_rdata == $past(cmp_c_control))
    else $error("control register not read back");

  a_mask_byte_order: assert property (
    reg_write && reg_address == dbc_pkg::off_a_mask0 && write_open
    |=> cmp_a_data_mask[31:24] == $past(reg_wdata)
        && $stable(cmp_a_data_mask[7:0]))
    else $error("mask byte 0 not in top bits");

  a_mask_excludes: assert property (
    ((bus_data ^ cmp_a_data) & cmp_a_data_mask) != 32'h00000000
    && !cmp_a_control[dbc_pkg::ctl_instruction_select_bit]
    |=> !match_a)
    else $error("masked-in data difference still matched");

  a_pc_select: assert property (
    cmp_c_control[dbc_pkg::ctl_enable_bit]
    && cmp_c_control[dbc_pkg::ctl_instruction_select_bit]
    && pc_valid && pc_address == cmp_c_address
    |=> match_c)
    else $error("pc address hit missed");

  a_rw_qualify: assert property (
    cmp_c_control[dbc_pkg::ctl_rwe_bit]
    && !cmp_c_control[dbc_pkg::ctl_instruction_select_bit]
    && bus_rw != cmp_c_control[dbc_pkg::ctl_rw_bit]
    |=> !match_c)
    else $error("rw mismatch still matched");

  a_disabled_quiet: assert property (
    !cmp_c_control[dbc_pkg::ctl_enable_bit] [*2] |-> !match_c)
    else $error("disabled comparator matched");

  a_ndb_invert: assert property (
    cmp_c_control[dbc_pkg::ctl_ndb_bit]
    && !cmp_c_control[dbc_pkg::ctl_instruction_select_bit]
    && ((bus_data ^ cmp_c_data) & cmp_c_data_mask) == 32'h00000000
    |=> !match_c)
    else $error("inequality mode matched equal data");

  a_range_uses_a: assert property (
    ab_pairing_mode && !cmp_a_control[dbc_pkg::ctl_enable_bit]
    |=> !match_b)
    else $error("range mode followed b control");

  a_b_address_hit: assert property (
    !ab_pairing_mode && cmp_b_control[dbc_pkg::ctl_enable_bit]
    && !cmp_b_control[dbc_pkg::ctl_instruction_select_bit]
    && !cmp_b_control[dbc_pkg::ctl_rwe_bit]
    && bus_valid && bus_address == cmp_b_address
    |=> match_b ##1 status[dbc_pkg::ev_match_b])
    else $error("b address hit missed or not flagged");

  c_match_a_seen: cover property (match_a);
  c_match_c_pc: cover property (
    cmp_c_control[dbc_pkg::ctl_instruction_select_bit] ##1 match_c);
  c_refused_write: cover property (refused ##1 irq);
  c_range_match_b: cover property (ab_pairing_mode ##1 match_b);

endmodule

// File: verification/dbc_core_bus_model.sv
// Purpose: processor bus and pc stream seen by the comparators
// Assumes: one data access and one pc per call, sys_clk domain
// Notes:   released lines show inverted values, never a stale match
module dbc_core_bus_model (
  input  wire logic        sys_clk,
  output logic      [23:0] bus_address,
  output logic      [31:0] bus_data,
  output logic             bus_rw,
  output logic             bus_valid,
  output logic      [23:0] pc_address,
  output logic             pc_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus_address = 24'h000000;
    bus_data = 32'h00000000;
    bus_rw = 1'b0;
    bus_valid = 1'b0;
    pc_address = 24'h000000;
    pc_valid = 1'b0;
  end

  // idle cycles first, then one cycle of access and pc
  task automatic drive(input logic [23:0] a, input logic [31:0] d,
                       input logic rw, input logic v,
                       input logic [23:0] pc, input logic pv, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    bus_address <= a;
    bus_data <= d;
    bus_rw <= rw;
    bus_valid <= v;
    pc_address <= pc;
    pc_valid <= pv;
    @(posedge sys_clk);
    bus_valid <= 1'b0;
    pc_valid <= 1'b0;
    bus_address <= ~a;
    bus_data <= ~d;
    bus_rw <= ~rw;
    pc_address <= ~pc;
  endtask
endmodule

// File: verification/testbench.sv
// Purpose: self-checking bench of the debug bus comparators
// Assumes: one sys_clk domain, byte register port
// Notes:   random setups from a 32-bit lfsr, reference model below
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] reg_address = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        armed = 1'b0;
  logic        trace_active = 1'b0;
  logic        ab_pairing_mode = 1'b0;
  logic [7:0]  cmp_a_control = 8'h00;
  logic [23:0] cmp_a_address = 24'h000000;
  logic [23:0] cmp_c_address = 24'h000000;
  logic [31:0] cmp_a_data = 32'h00000000;
  logic [31:0] cmp_c_data = 32'h00000000;
  logic [31:0] cmp_c_data_mask = 32'h00000000;
  logic [31:0] seed = 32'h557fd26b;
  logic [7:0]  reg_rdata;
  logic [23:0] bus_address;
  logic [23:0] pc_address;
  logic [31:0] bus_data;
  logic        bus_rw;
  logic        bus_valid;
  logic        pc_valid;
  logic        match_a;
  logic        match_b;
  logic        match_c;
  logic        irq;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [15:0] ofs [9];
  logic [7:0]  keep [9];
  logic [7:0]  v [9];
  logic [31:0] r, dat, da, dc, mc;
  logic [23:0] ba, adr, pca;
  logic [3:0]  st;
  logic        rw, bv, pv, ea, eb, ec;
  logic [7:0]  bc;

  dbc_debug_comparators u_dut (.sys_clk, .reset, .reg_address, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .armed, .trace_active,
    .ab_pairing_mode, .cmp_a_control, .cmp_a_address, .cmp_a_data,
    .cmp_c_address, .cmp_c_data, .cmp_c_data_mask, .bus_address, .bus_data,
    .bus_rw, .bus_valid, .pc_address, .pc_valid, .match_a, .match_b,
    .match_c, .irq);
  dbc_core_bus_model u_bus (.sys_clk, .bus_address, .bus_data, .bus_rw,
    .bus_valid, .pc_address, .pc_valid);

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic hit(input logic [7:0] c, input logic [23:0] av,
                               input logic [31:0] dv, input logic [31:0] m,
                               input logic hd);
    logic ok;
    if (c[5]) begin
      ok = pv && pca == av;
    end else begin
      ok = bv && adr == av && (!c[2] || rw == c[3]);
      if (hd) begin
        ok = ok && ((((dat ^ dv) & m) == 0) ^ c[6]);
      end
    end
    return c[0] && ok;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] lk);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_wdata <= d;
    armed <= lk[0];
    trace_active <= lk[1];
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    ofs = '{dbc_pkg::off_a_mask0, dbc_pkg::off_a_mask1, dbc_pkg::off_a_mask2,
      dbc_pkg::off_a_mask3, dbc_pkg::off_b_ctl, dbc_pkg::off_b_addr_high,
      dbc_pkg::off_b_addr_mid, dbc_pkg::off_b_addr_low, dbc_pkg::off_c_ctl};
    keep = '{8'hff, 8'hff, 8'hff, 8'hff, dbc_pkg::b_ctl_bits, 8'hff, 8'hff,
      8'hff, dbc_pkg::c_ctl_bits};
    st = 4'h0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    `CHK("outputs", 4'h0, {match_a, match_b, match_c, irq})
    for (int k = 0; k < 9; k++) begin
      rd_chk(ofs[k], 8'h00);
    end
    wr(dbc_pkg::off_b_ctl, 8'hff, 2'b01);
    wr(dbc_pkg::off_a_mask0, 8'hff, 2'b10);
    wr(16'h0200, 8'hff, 2'b00);
    rd_chk(dbc_pkg::off_b_ctl, 8'h00);
    rd_chk(dbc_pkg::off_a_mask0, 8'h00);
    rd_chk(16'h0200, 8'h00);
    rd_chk(dbc_pkg::off_status, 8'h08);
    rd_chk(dbc_pkg::off_status, 8'h00);
    wr(dbc_pkg::off_irq_mask, 8'h02, 2'b00);
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      for (int k = 0; k < 9; k++) v[k] = 8'(rnd());
      for (int k = 0; k < 9; k++) wr(ofs[k], v[k], 2'b00);
      @(negedge sys_clk);
      `CHK("irq", |(st & 4'h2), irq)
      if (i % 50 == 0) begin
        for (int k = 0; k < 9; k++) begin
          rd_chk(ofs[k], v[k] & keep[k]);
        end
      end
      ba = {v[5], v[6], v[7]};
      da = rnd();
      dc = rnd();
      mc = rnd();
      @(posedge sys_clk);
      ab_pairing_mode <= r[9];
      cmp_a_control <= 8'(rnd());
      cmp_a_address <= r[2] ? ba : 24'(rnd());
      cmp_c_address <= r[3] ? ba : 24'(rnd());
      cmp_a_data <= da;
      cmp_c_data <= dc;
      cmp_c_data_mask <= mc;
      adr = r[1] ? ba : 24'(rnd());
      pca = r[4] ? ba : 24'(rnd());
      dat = r[5] ? da ^ (rnd() & ~{v[0], v[1], v[2], v[3]}) :
            r[6] ? dc ^ (rnd() & ~mc) : rnd();
      rw = r[7];
      bv = r[8] | r[10];
      pv = r[11] | r[12];
      u_bus.drive(adr, dat, rw, bv, pca, pv, int'(r[14:13]));
      @(negedge sys_clk);
      bc = ab_pairing_mode ? cmp_a_control & 8'hbf : v[4] & keep[4];
      ea = hit(cmp_a_control & 8'hbf, cmp_a_address, cmp_a_data,
               {v[0], v[1], v[2], v[3]}, 1'b1);
      eb = hit(bc, ba, 32'h0, 32'h0, 1'b0);
      ec = hit(v[8] & keep[8], cmp_c_address, cmp_c_data, cmp_c_data_mask,
               1'b1);
      `CHK("match_a", ea, match_a)
      `CHK("match_b", eb, match_b)
      `CHK("match_c", ec, match_c)
      st = st | {1'b0, match_c, match_b, match_a};
    end
    @(negedge sys_clk);
    `CHK("irq", |(st & 4'h2), irq)
    rd_chk(dbc_pkg::off_status, {4'h0, st});
    `CHK("irq", 1'b0, irq)
    end_of_test();
  end
endmodule
